// file: verilog/elvc_pkg.sv
package elvc_pkg;
    // number of request sources and register data width
    localparam int unsigned ELVC_NSRC = 8;
    localparam int unsigned ELVC_DW = 32;
    // apb byte offsets of the register words
    localparam logic [11:0] ELVC_OFS_PEND = 12'h000; // read pending, write clear
    localparam logic [11:0] ELVC_OFS_EN = 12'h004;
    localparam logic [11:0] ELVC_OFS_EVT = 12'h008;
    localparam logic [11:0] ELVC_OFS_EVM = 12'h00C;
    // reset values
    localparam logic [7:0] ELVC_PEND_RST = 8'h00;
    localparam logic [7:0] ELVC_EN_RST = 8'h00;
    localparam logic [2:0] ELVC_EVT_RST = 3'h0;
    // event status bit positions
    localparam int unsigned ELVC_EVT_LATCH = 0; // a request edge was latched
    localparam int unsigned ELVC_EVT_EMPTY = 1; // acknowledge found nothing
    localparam int unsigned ELVC_EVT_VEC = 2; // vector delivered from rom
    localparam int unsigned ELVC_NEVT = 3;
    // processor priority levels handled here
    localparam logic [4:0] ELVC_LVL_14 = 5'h14;
    localparam logic [4:0] ELVC_LVL_15 = 5'h15;
    localparam logic [4:0] ELVC_LVL_16 = 5'h16;
    localparam logic [4:0] ELVC_LVL_17 = 5'h17;
    // rom vector addresses
    localparam logic [31:0] ELVC_ROM_BASE15 = 32'h2004_0020;
    localparam logic [31:0] ELVC_ROM_ADR14 = 32'h2004_0040;
    localparam logic [31:0] ELVC_ROM_ADR16 = 32'h2004_0048;
    localparam logic [31:0] ELVC_ROM_ADR17 = 32'h2004_004C;
    localparam int unsigned ELVC_IDX_SHIFT = 2;
    localparam logic [31:0] ELVC_PASSIVE_VEC = 32'h0000_0000;

    // acknowledge request from the processor
    typedef struct packed {
        logic req; // held high until the answer pulse
        logic [4:0] level; // processor_priority_level being acknowledged
    } elvc_ack_t;

    // rom read request towards the boot rom
    typedef struct packed {
        logic req; // held high until rom ack
        logic [31:0] addr; // longword aligned
    } elvc_rom_t;

    // vector answer back to the processor
    typedef struct packed {
        logic done; // one cycle pulse
        logic [31:0] vec;
    } elvc_vec_t;
endpackage : elvc_pkg

// file: verilog/elvc_ctrl.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module elvc_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device request lines, active high
    input wire logic [7:0] dev_req,
    // processor side
    output logic cpu_irq_n,
    input wire elvc_pkg::elvc_ack_t ack_in,
    output elvc_pkg::elvc_vec_t vec_out,
    // boot rom side
    output elvc_pkg::elvc_rom_t rom_out,
    input wire logic rom_ack,
    input wire logic [31:0] rom_rdata,
    // event interrupt
    output logic evt_irq
);
    import elvc_pkg::*;

    typedef enum logic [1:0] {
        ELVC_IDLE,
        ELVC_ROM,
        ELVC_HOLD
    } elvc_state_t;

    // highest set bit wins, 7 over 0
    function automatic logic [2:0] elvc_winner(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < ELVC_NSRC; i++) begin
            if (v[i]) begin
                idx = i[2:0]; // later (higher) bits override
            end
        end
        return idx;
    endfunction : elvc_winner

    // level in the served window
    function automatic logic elvc_our_level(input logic [4:0] lvl);
        return (lvl == ELVC_LVL_14) || (lvl == ELVC_LVL_15) ||
            (lvl == ELVC_LVL_16) || (lvl == ELVC_LVL_17);
    endfunction : elvc_our_level

    logic [7:0] req_meta_ff; // first stage, read only by second
    logic [7:0] req_sync_ff; // synchronised level
    logic [7:0] req_prev_ff; // previous synchronised level
    logic [7:0] rise; // one cycle per edge
    logic [7:0] pend_ff;
    logic [7:0] nxt_pend;
    logic [7:0] en_ff;
    logic [ELVC_NEVT-1:0] evt_ff;
    logic [ELVC_NEVT-1:0] evm_ff;
    logic [ELVC_NEVT-1:0] evt_set;
    logic [7:0] act; // pending and enabled
    logic [7:0] clr_w; // clear mask from apb write
    logic [7:0] ack_clr; // one-hot clear from acknowledge
    logic irq_n_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic wr_acc; // access phase of a write
    logic setup; // setup phase
    logic take; // acknowledge accepted this cycle
    logic take15;
    elvc_state_t state_ff;
    logic rom_req_ff;
    logic [31:0] rom_addr_ff;
    logic vec_done_ff;
    logic [31:0] vec_ff;

    assign act = pend_ff & en_ff;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign take = (state_ff == ELVC_IDLE) && ack_in.req &&
        elvc_our_level(ack_in.level);
    assign take15 = take && (ack_in.level == ELVC_LVL_15);

    // two flop synchroniser then edge history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_meta_ff <= 8'h00;
            req_sync_ff <= 8'h00;
            req_prev_ff <= 8'h00;
        end else begin
            req_meta_ff <= dev_req;
            req_sync_ff <= req_meta_ff;
            req_prev_ff <= req_sync_ff;
        end
    end

    // edge detect on synced level only; a held level gives no edge
    assign rise = req_sync_ff & ~req_prev_ff;

    // clear mask from a write to the shared pending address
    assign clr_w = (wr_acc && paddr == ELVC_OFS_PEND) ?
        pwdata[7:0] : 8'h00;
    // acknowledge clears only its winner, enables untouched
    assign ack_clr = (take15 && |act) ?
        (8'h01 << elvc_winner(act)) : 8'h00;

    // per source pending latch, same bit index in every register
    generate
        for (genvar g = 0; g < ELVC_NSRC; g++) begin : g_pend
            // set independent of enable; set beats any clear
            assign nxt_pend[g] = rise[g] ||
                (pend_ff[g] && !clr_w[g] && !ack_clr[g]);
        end
    endgenerate

    // pending register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_ff <= ELVC_PEND_RST;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // enable register, written only by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_ff <= ELVC_EN_RST;
        end else if (wr_acc && paddr == ELVC_OFS_EN) begin
            en_ff <= pwdata[7:0];
        end
    end

    // processor request, registered so the pin never glitches
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= !(|act);
        end
    end
    assign cpu_irq_n = irq_n_ff;

    // acknowledge sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ELVC_IDLE;
            rom_req_ff <= 1'b0;
            rom_addr_ff <= 32'h0000_0000;
            vec_done_ff <= 1'b0;
            vec_ff <= 32'h0000_0000;
        end else begin
            vec_done_ff <= 1'b0;
            case (state_ff)
                ELVC_IDLE: begin
                    if (take15 && !(|act)) begin
                        // passive release: nothing to fetch
                        vec_ff <= ELVC_PASSIVE_VEC;
                        vec_done_ff <= 1'b1;
                        state_ff <= ELVC_HOLD;
                    end else if (take15) begin
                        rom_addr_ff <= ELVC_ROM_BASE15 |
                            {27'h0, elvc_winner(act), 2'h0};
                        rom_req_ff <= 1'b1;
                        state_ff <= ELVC_ROM;
                    end else if (take) begin
                        // one fixed longword per other level
                        if (ack_in.level == ELVC_LVL_14) begin
                            rom_addr_ff <= ELVC_ROM_ADR14;
                        end else if (ack_in.level == ELVC_LVL_16) begin
                            rom_addr_ff <= ELVC_ROM_ADR16;
                        end else begin
                            rom_addr_ff <= ELVC_ROM_ADR17;
                        end
                        rom_req_ff <= 1'b1;
                        state_ff <= ELVC_ROM;
                    end
                end
                ELVC_ROM: begin
                    if (rom_ack) begin
                        rom_req_ff <= 1'b0;
                        vec_ff <= rom_rdata;
                        vec_done_ff <= 1'b1;
                        state_ff <= ELVC_HOLD;
                    end
                end
                default: begin
                    // wait for the processor to drop its request,
                    // otherwise a held request would be served twice
                    if (!ack_in.req) begin
                        state_ff <= ELVC_IDLE;
                    end
                end
            endcase
        end
    end
    assign rom_out.req = rom_req_ff;
    assign rom_out.addr = rom_addr_ff;
    assign vec_out.done = vec_done_ff;
    assign vec_out.vec = vec_ff;

    // event sources for the sticky status
    always_comb begin
        evt_set = '0;
        evt_set[ELVC_EVT_LATCH] = |rise;
        evt_set[ELVC_EVT_EMPTY] = take15 && !(|act);
        evt_set[ELVC_EVT_VEC] = (state_ff == ELVC_ROM) && rom_ack;
    end

    // sticky status, write one to clear, new event wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_ff <= ELVC_EVT_RST;
        end else if (wr_acc && paddr == ELVC_OFS_EVT) begin
            evt_ff <= evt_set | (evt_ff & ~pwdata[ELVC_NEVT-1:0]);
        end else begin
            evt_ff <= evt_set | evt_ff;
        end
    end

    // event mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evm_ff <= ELVC_EVT_RST;
        end else if (wr_acc && paddr == ELVC_OFS_EVM) begin
            evm_ff <= pwdata[ELVC_NEVT-1:0];
        end
    end
    assign evt_irq = |(evt_ff & evm_ff);

    // read data captured in setup; reads have no side effect
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            pslverr_ff <= 1'b0;
            if (paddr == ELVC_OFS_PEND) begin
                prdata_ff <= {24'h0, pend_ff};
            end else if (paddr == ELVC_OFS_EN) begin
                prdata_ff <= {24'h0, en_ff};
            end else if (paddr == ELVC_OFS_EVT) begin
                prdata_ff <= {29'h0, evt_ff};
            end else if (paddr == ELVC_OFS_EVM) begin
                prdata_ff <= {29'h0, evm_ff};
            end else begin
                // unmapped: zero data and an error answer
                prdata_ff <= 32'h0000_0000;
                pslverr_ff <= 1'b1;
            end
        end
    end
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign pready = 1'b1; // zero wait states

    // assertions
    sequence s_take_win;
        take15 && (|act);
    endsequence
    sequence s_take_empty;
        take15 && !(|act);
    endsequence

    edge_sets_a: assert property (@(posedge clk) disable iff (!rst_b)
        ((pend_ff & $past(rise)) == $past(rise)))
        else $error("latched edge did not set pending");
    no_level_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        ((pend_ff & ~$past(pend_ff) & ~$past(rise)) == 8'h00))
        else $error("pending set without an edge");
    sync_delay_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(dev_req[0]) ##1 dev_req[0] ##1 dev_req[0] |=> pend_ff[0])
        else $error("source 0 edge not latched after sync");
    irq_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (cpu_irq_n == !(|$past(act))))
        else $error("cpu_irq_n does not follow pending and enable");
    clr_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_acc && paddr == ELVC_OFS_PEND |=>
        ((pend_ff & $past(pwdata[7:0]) & ~$past(rise)) == 8'h00))
        else $error("clear write left a bit set");
    ack_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_take_win |=> (pend_ff == (($past(pend_ff) & ~$past(ack_clr)) |
        $past(rise))) && (en_ff == $past(en_ff)))
        else $error("acknowledge cleared the wrong bits");
    rom15_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_take_win |=> rom_out.req && rom_out.addr ==
        (ELVC_ROM_BASE15 | {27'h0, $past(elvc_winner(act)), 2'h0}))
        else $error("level 15h rom address wrong");
    passive_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_take_empty |=> vec_out.done && vec_out.vec == 32'h0 &&
        !rom_out.req)
        else $error("empty acknowledge not answered with zero");
    vec_return_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_ff == ELVC_ROM) && rom_ack |=>
        vec_out.done && vec_out.vec == $past(rom_rdata) && !rom_out.req)
        else $error("rom data not returned as vector");
    read_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
        psel && !pwrite && !take |=> pend_ff == ($past(pend_ff) |
        $past(rise)))
        else $error("read changed pending");
endmodule : elvc_ctrl

// file: sim/elvc_rom_model.sv
`timescale 1ns/1ps
// boot rom stand-in: answers after lat idle cycles
module elvc_rom_model
    import elvc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire elvc_rom_t rom_in,
    input wire logic [1:0] lat,
    output logic rom_ack,
    output logic [31:0] rom_rdata
);
    logic [1:0] cnt_ff; // wait cycles so far
    logic ack_ff; // one-cycle answer pulse
    logic [31:0] dat_ff; // data lines
    // one answer per request; data garbage outside the ack cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 2'h0;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= 1'b0;
            dat_ff <= ~dat_ff; // no stale data may pass for a vector
            if (rom_in.req && !ack_ff) begin
                if (cnt_ff == lat) begin
                    ack_ff <= 1'b1;
                    dat_ff <= ~rom_in.addr ^ 32'h0000_0200;
                    cnt_ff <= 2'h0;
                end else begin
                    cnt_ff <= cnt_ff + 2'h1;
                end
            end
        end
    end
    assign rom_ack = ack_ff;
    assign rom_rdata = dat_ff;
endmodule : elvc_rom_model

// file: sim/elvc_ctrl_tb.sv
`timescale 1ns/1ps
module elvc_ctrl_tb;
    import elvc_pkg::*;
    localparam logic [11:0] UNMAP = 12'h010; // no register here
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic cpu_irq_n, rom_ack, evt_irq, err, seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rom_rdata, rd, r, v, a;
    logic [7:0] dev_req;
    logic [7:0] pe; // expected pending
    logic [7:0] en; // expected enables
    logic [1:0] lat; // rom latency
    elvc_ack_t ack_in;
    elvc_vec_t vec_out;
    elvc_rom_t rom_out;
    int num_errors, samples_checked;

    elvc_ctrl i_elvc_ctrl (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_req(dev_req), .cpu_irq_n(cpu_irq_n),
        .ack_in(ack_in), .vec_out(vec_out), .rom_out(rom_out),
        .rom_ack(rom_ack), .rom_rdata(rom_rdata), .evt_irq(evt_irq));
    elvc_rom_model i_elvc_rom_model (.clk(clk), .rst_b(rst_b),
        .rom_in(rom_out), .lat(lat), .rom_ack(rom_ack),
        .rom_rdata(rom_rdata));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // highest set bit, -1 if none
    function int top(input logic [7:0] x);
        top = -1;
        for (int k = 0; k < 8; k++) begin
            if (x[k]) begin
                top = k;
            end
        end
    endfunction : top
    // contents the rom model holds at an address
    function logic [31:0] word(input logic [31:0] ad);
        return ~ad ^ 32'h0000_0200;
    endfunction : word

    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tmo;
        num_errors++;
        $display("Error answer expected within bound seen none");
        report_and_stop();
    endtask : tmo
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // one apb transfer; request held until pready at an edge
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            tmo();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input logic [11:0] ad, input logic [31:0] e, input string n);
        apb(1'b0, ad, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    // acknowledge cycle; notes any rom address on the way
    task ack(input logic [4:0] l);
        int n;
        seen = 1'b0;
        a = 32'h0;
        @(posedge clk);
        ack_in <= '{req: 1'b1, level: l};
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (rom_out.req === 1'b1) begin
                seen = 1'b1;
                a = rom_out.addr;
            end
        end while (vec_out.done !== 1'b1 && n < 50);
        if (vec_out.done !== 1'b1) begin
            tmo();
        end
        v = vec_out.vec;
        @(posedge clk);
        ack_in.req <= 1'b0;
        wt(2);
    endtask : ack
    // level 15h acknowledge against the pending model
    task ack15;
        int i;
        logic [31:0] ea;
        i = top(pe & en);
        ea = ELVC_ROM_BASE15 | (32'(i) << ELVC_IDX_SHIFT);
        ack(ELVC_LVL_15);
        if (i < 0) begin
            chk("passive vec", ELVC_PASSIVE_VEC, v);
            chk("rom used", 32'h0, 32'(seen));
        end else begin
            chk("rom addr", ea, a);
            chk("vec", word(ea), v);
            pe[i] = 1'b0;
        end
        rdc(ELVC_OFS_PEND, 32'(pe), "pending");
        chk("irq_n", 32'(!(|(pe & en))), 32'(cpu_irq_n));
    endtask : ack15
    task ackf(input logic [4:0] l, input logic [31:0] ea);
        ack(l);
        chk("rom addr", ea, a);
        chk("vec", word(ea), v);
    endtask : ackf

    // main sequence
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        dev_req = 8'h0;
        ack_in = '0;
        lat = 2'h0;
        num_errors = 0;
        samples_checked = 0;
        r = 32'hC30F;
        wt(16);
        rst_b <= 1'b1;
        wt(1);
        rdc(ELVC_OFS_PEND, 32'(ELVC_PEND_RST), "pending");
        rdc(ELVC_OFS_EN, 32'(ELVC_EN_RST), "enables");
        chk("irq_n", 32'h1, 32'(cpu_irq_n));
        $display("test reset done");
        dev_req <= 8'h01;
        wt(5);
        rdc(ELVC_OFS_PEND, 32'h01, "pending");
        chk("irq_n", 32'h1, 32'(cpu_irq_n));
        apb(1'b1, ELVC_OFS_PEND, 32'h01);
        wt(5);
        rdc(ELVC_OFS_PEND, 32'h00, "pending");
        dev_req <= 8'h00;
        wt(2);
        dev_req <= 8'h81;
        wt(5);
        apb(1'b1, ELVC_OFS_PEND, 32'h80);
        rdc(ELVC_OFS_PEND, 32'h01, "pending");
        rdc(ELVC_OFS_PEND, 32'h01, "pending");
        en = 8'h01;
        apb(1'b1, ELVC_OFS_EN, 32'h01);
        rdc(ELVC_OFS_EN, 32'h01, "enables");
        chk("irq_n", 32'h0, 32'(cpu_irq_n));
        dev_req <= 8'h00;
        pe = 8'h01;
        // let every line settle low through the synchroniser first
        wt(3);
        $display("test edges done");
        for (int k = 0; k < 6; k++) begin
            r = lfsr(r);
            dev_req <= r[7:0];
            wt(5);
            dev_req <= 8'h00;
            wt(5);
            pe = pe | r[7:0];
            en = r[15:8];
            lat <= r[17:16];
            apb(1'b1, ELVC_OFS_EN, {24'h0, en});
            rdc(ELVC_OFS_PEND, 32'(pe), "pending");
            chk("irq_n", 32'(!(|(pe & en))), 32'(cpu_irq_n));
            ack15();
            ack15();
        end
        repeat (9) ack15();
        apb(1'b1, ELVC_OFS_PEND, 32'hFF);
        pe = 8'h00;
        rdc(ELVC_OFS_PEND, 32'h00, "pending");
        // corner: acknowledge with nothing pending must stay off the rom
        ack15();
        $display("test random done");
        ackf(ELVC_LVL_14, ELVC_ROM_ADR14);
        ackf(ELVC_LVL_16, ELVC_ROM_ADR16);
        ackf(ELVC_LVL_17, ELVC_ROM_ADR17);
        $display("test levels done");
        // every event kind has happened by now
        rdc(ELVC_OFS_EVT, 32'h7, "event status");
        apb(1'b1, ELVC_OFS_EVM, 32'h0);
        wt(1);
        chk("evt_irq", 32'h0, 32'(evt_irq));
        apb(1'b1, ELVC_OFS_EVM, 32'h7);
        wt(1);
        chk("evt_irq", 32'h1, 32'(evt_irq));
        apb(1'b1, ELVC_OFS_EVT, 32'h7);
        wt(1);
        chk("evt_irq", 32'h0, 32'(evt_irq));
        rdc(ELVC_OFS_EVT, 32'h0, "event status");
        apb(1'b0, UNMAP, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        $display("test events done");
        report_and_stop();
    end
endmodule : elvc_ctrl_tb
